// *** design/ppic_bus_if.sv ***
interface ppic_bus_if;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic start_stb;
    modport source (output wr_stb, output wr_addr, output wr_data,
        output start_stb);
    modport sink (input wr_stb, input wr_addr, input wr_data,
        input start_stb);
endinterface

// *** design/ppic_i2c_slave.sv ***
module ppic_i2c_slave
    import ppic_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rstn, // async reset, active low
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin
    output logic sda_oe_n, // low pulls data line low
    input wire logic addr_sel, // address-select pin
    ppic_bus_if.source bus // register writes
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_REGNUM = 2'b11,
        ST_DATA = 2'b10
    } ppic_i2c_state_type;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl_q;
        logic sda_q;
        ppic_i2c_state_type state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic ack;
        logic ack_ok;
        logic [7:0] ptr;
        logic wr_stb;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic start_stb;
    } ppic_i2c_reg_type;

    ppic_i2c_reg_type r, next_r;
    logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

    always_comb begin
        next_r = r;
        next_r.scl_sync = {r.scl_sync[1:0], scl_in};
        next_r.sda_sync = {r.sda_sync[1:0], sda_in};
        // a level counts once stages two and three agree
        scl_s = (r.scl_sync[2] == r.scl_sync[1]) ? r.scl_sync[1] : r.scl_q;
        sda_s = (r.sda_sync[2] == r.sda_sync[1]) ? r.sda_sync[1] : r.sda_q;
        next_r.scl_q = scl_s;
        next_r.sda_q = sda_s;
        scl_rise = scl_s && !r.scl_q;
        scl_fall = !scl_s && r.scl_q;
        start_c = scl_s && r.scl_q && r.sda_q && !sda_s;
        stop_c = scl_s && r.scl_q && !r.sda_q && sda_s;
        next_r.wr_stb = 1'b0;
        next_r.start_stb = 1'b0;
        if (start_c) begin
            next_r.state = ST_ADDR;
            next_r.bit_cnt = 4'h0;
            next_r.ack = 1'b0;
            next_r.start_stb = 1'b1;
        end else if (stop_c) begin
            next_r.state = ST_IDLE;
            next_r.ack = 1'b0;
        end else if (r.state != ST_IDLE) begin
            // bits count on the rise, so the fall just after a start is idle
            if (scl_rise && r.bit_cnt < 4'd8) begin
                next_r.shift = {r.shift[6:0], sda_s};
                next_r.bit_cnt = r.bit_cnt + 4'h1;
            end
            if (scl_fall) begin
                if (r.bit_cnt == 4'd8) begin
                    next_r.bit_cnt = 4'd9;
                    next_r.ack_ok = 1'b1;
                    case (r.state)
                        ST_ADDR: begin
                            next_r.ack_ok = (r.shift[0] == 1'b0) &&
                                (r.shift[7:1] == (addr_sel ?
                                ADDR_SELECT_HIGH : ADDR_SELECT_LOW));
                        end
                        ST_REGNUM: begin
                            next_r.ptr = r.shift;
                        end
                        default: begin
                            next_r.wr_stb = 1'b1;
                            next_r.wr_addr = r.ptr;
                            next_r.wr_data = r.shift;
                            next_r.ptr = r.ptr + 8'h01;
                        end
                    endcase
                    next_r.ack = next_r.ack_ok;
                end else if (r.bit_cnt == 4'd9) begin
                    next_r.ack = 1'b0;
                    next_r.bit_cnt = 4'h0;
                    if (!r.ack_ok) begin
                        next_r.state = ST_IDLE;
                    end else if (r.state == ST_ADDR) begin
                        next_r.state = ST_REGNUM;
                    end else begin
                        next_r.state = ST_DATA;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sda_oe_n = !r.ack;
    assign bus.wr_stb = r.wr_stb;
    assign bus.wr_addr = r.wr_addr;
    assign bus.wr_data = r.wr_data;
    assign bus.start_stb = r.start_stb;
endmodule

// *** design/ppic_pkg.sv ***
package ppic_pkg;
    // register numbers
    localparam logic [7:0] REG_CONTROL_CALIBRATION = 8'h00;
    localparam logic [7:0] REG_DRIVE_PERIOD = 8'h01;
    localparam logic [7:0] REG_PULSE_COUNT_HIGH_DIRECTION = 8'h02;
    localparam logic [7:0] REG_PULSE_COUNT_LOW = 8'h03;
    localparam logic [7:0] REG_PULSE_WIDTH = 8'h04;
    localparam logic [7:0] REG_PHASE_SHIFT = 8'h05;
    localparam logic [7:0] REG_LAST = 8'h05;
    // slave addresses
    localparam logic [6:0] ADDR_SELECT_LOW = 7'h54;
    localparam logic [6:0] ADDR_SELECT_HIGH = 7'h55;
    // field positions
    localparam int DIR_BIT = 6;
    localparam int PERIOD_MSB_BIT = 7;
    localparam int CAL_FIELD_LSB = 2;
    localparam int HYBRID_BIT = 5;
    localparam int PHASE1_EN_BIT = 1;
    localparam int PHASE2_EN_BIT = 0;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h03;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    // calibrate-now codes
    localparam logic [1:0] CAL_NONE = 2'b00;
    localparam logic [1:0] CAL_INCREMENTAL = 2'b01;
    localparam logic [1:0] CAL_SWEEP = 2'b10;
    // timing
    localparam int CORE_CLK_HZ = 20_000_000;
    localparam int PERIOD_STEP_NS = 40;
    localparam int CORE_CLK_NS = 50;
    localparam int STEP_CYCLES = (PERIOD_STEP_NS < CORE_CLK_NS) ? 1
        : PERIOD_STEP_NS / CORE_CLK_NS;
    localparam int HYBRID_FRAME = 4;
endpackage

// *** design/ppic_top.sv ***
// Notes on behaviour
// - answer address 54h with select pin low, 55h with it high.
// - only write transfers; a read address is not acknowledged.
// - pull data low on ninth clock when the address matches.
// - second byte is the register number and starting pointer.
// - later bytes go to successive registers, pointer advances each byte.
// - non-zero count written into registers 02/03 starts pulses at period.
// - count drops once per pulse until zero or zero is written.
// - pulse count is eleven bits, maximum 2047.
// - period register counts oscillator steps of 40 ns; here one step is one 50 ns core clock.
// - pulse width zero gives 50 percent high; smaller widths shorten it.
// - phase shift zero offsets the waveforms by a quarter period.
// - two square waveforms; direction bit picks the leading phase.
// - full or half bridge; hybrid setting sets full-to-half ratio.
// - calibration trims oscillator, never the programmed period.
// - power-down pin gives stand-by; host uses it when idle.
// - bit 6 of the high count byte is the direction.
// - bit 7 of the high count byte is the period msb.
// - zero count or power-down stops at once, outputs low.
// - calibrate field: none, incremental, sweep, reserved.
module ppic_top
    import ppic_pkg::*;
(
    input wire logic core_clk, // 20 MHz core clock
    input wire logic rstn, // async reset, active low
    input wire logic powerdown_n_pin, // stand-by when low, async-sampled
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin level
    output logic sda_out, // bus data drive value, always low
    output logic sda_oe_n, // low while pulling data line low
    input wire logic addr_sel, // address-select pin
    output logic phase1_high, // phase 1 high-side drive
    output logic phase1_low, // phase 1 low-side drive
    output logic phase2_high, // phase 2 high-side drive
    output logic phase2_low, // phase 2 low-side drive
    output logic [1:0] calibrate_now_field, // calibration request to trim
    output logic [1:0] dead_time_field, // dead time to bridge stage
    output logic motor_running // pulses are being issued
);
    ppic_bus_if bus ();

    ppic_i2c_slave u_slave (
        .core_clk(core_clk),
        .rstn(rstn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_n(sda_oe_n),
        .addr_sel(addr_sel),
        .bus(bus)
    );

    typedef struct packed {
        logic [2:0] pd_sync;
        logic pd_active;
        logic [7:0] control_calibration;
        logic [7:0] drive_period;
        logic [7:0] pulse_count_high_direction;
        logic [7:0] pulse_pend_low;
        logic [7:0] pulse_width;
        logic [7:0] phase_shift;
        logic [10:0] count;
        logic [8:0] phase_ctr;
        logic [7:0] step_ctr;
        logic [1:0] hybrid_ctr;
        logic running;
        logic p1;
        logic p2;
        logic full_bridge;
    } ppic_top_reg_type;

    ppic_top_reg_type r, next_r;
    logic [8:0] period, half, high_time, shift_amt, p2_pos;
    logic step, wrap, direction;

    // ==============================================================
    // register writes, sequencer
    // ==============================================================
    function automatic logic in_high(input logic [8:0] pos,
        input logic [8:0] ht);
        in_high = pos < ht;
    endfunction

    always_comb begin
        next_r = r;
        next_r.pd_sync = {r.pd_sync[1:0], powerdown_n_pin};
        if (r.pd_sync[2] == r.pd_sync[1]) begin
            next_r.pd_active = !r.pd_sync[1];
        end
        period = {r.pulse_count_high_direction[PERIOD_MSB_BIT],
            r.drive_period};
        if (period == 9'h000) begin
            period = 9'h001;
        end
        half = {1'b0, period[8:1]};
        high_time = (r.pulse_width == ZERO_RESET) ? half
            : {1'b0, r.pulse_width};
        shift_amt = (r.phase_shift == ZERO_RESET) ? {2'b00, period[8:2]}
            : {1'b0, r.phase_shift};
        direction = r.pulse_count_high_direction[DIR_BIT];
        step = (r.step_ctr >= 8'(STEP_CYCLES - 1));
        wrap = step && (r.phase_ctr >= period - 9'h001);
        p2_pos = (r.phase_ctr >= shift_amt) ? r.phase_ctr - shift_amt
            : r.phase_ctr + period - shift_amt;
        if (r.running) begin
            next_r.step_ctr = step ? 8'h00 : r.step_ctr + 8'h01;
            if (step) begin
                next_r.phase_ctr = wrap ? 9'h000 : r.phase_ctr + 9'h001;
            end
            next_r.p1 = direction ? in_high(r.phase_ctr, high_time)
                : in_high(p2_pos, high_time);
            next_r.p2 = direction ? in_high(p2_pos, high_time)
                : in_high(r.phase_ctr, high_time);
            if (wrap) begin
                next_r.hybrid_ctr = r.hybrid_ctr + 2'b01;
                next_r.count = r.count - 11'h001;
                if (r.count == 11'h001) begin
                    next_r.running = 1'b0;
                end
            end
        end
        // hybrid spreads full-bridge pulses over a frame
        if (!r.control_calibration[HYBRID_BIT]) begin
            next_r.full_bridge = 1'b1;
        end else begin
            next_r.full_bridge = ({1'b0, r.hybrid_ctr}
                * 3'(HYBRID_FRAME - 1)) % 3'(HYBRID_FRAME)
                < 3'(r.pulse_width[7:6]);
        end
        if (bus.wr_stb && bus.wr_addr <= REG_LAST) begin
            if (bus.wr_addr == REG_CONTROL_CALIBRATION) begin
                next_r.control_calibration = bus.wr_data;
            end else if (bus.wr_addr == REG_DRIVE_PERIOD) begin
                next_r.drive_period = bus.wr_data;
            end else if (bus.wr_addr == REG_PULSE_COUNT_HIGH_DIRECTION) begin
                next_r.pulse_count_high_direction = bus.wr_data;
            end else if (bus.wr_addr == REG_PULSE_COUNT_LOW) begin
                next_r.pulse_pend_low = bus.wr_data;
                // low byte completes the eleven-bit count
                next_r.count = {r.pulse_count_high_direction[2:0],
                    bus.wr_data};
                if ({r.pulse_count_high_direction[2:0], bus.wr_data}
                    == 11'h000) begin
                    next_r.running = 1'b0;
                    next_r.p1 = 1'b0;
                    next_r.p2 = 1'b0;
                end else if (!r.running) begin
                    next_r.running = 1'b1;
                    next_r.phase_ctr = 9'h000;
                    next_r.step_ctr = 8'h00;
                end
            end else if (bus.wr_addr == REG_PULSE_WIDTH) begin
                next_r.pulse_width = bus.wr_data;
            end else begin
                next_r.phase_shift = bus.wr_data;
            end
        end
        if (!next_r.running) begin
            next_r.p1 = 1'b0;
            next_r.p2 = 1'b0;
        end
        // power-down returns registers to reset values and stops drive
        if (r.pd_active) begin
            next_r = '0;
            next_r.pd_sync = {r.pd_sync[1:0], powerdown_n_pin};
            next_r.pd_active = !(r.pd_sync[2] == r.pd_sync[1] &&
                r.pd_sync[1]);
            next_r.control_calibration = CONTROL_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.pd_active <= 1'b1;
            r.control_calibration <= CONTROL_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ==============================================================
    // outputs
    // ==============================================================
    // half bridge keeps both low sides off; full drives each enabled low side while running and its high side is off
    assign phase1_high = r.p1 && r.control_calibration[PHASE1_EN_BIT];
    assign phase1_low = r.running && r.full_bridge &&
        r.control_calibration[PHASE1_EN_BIT] && !r.p1;
    assign phase2_high = r.p2 && r.control_calibration[PHASE2_EN_BIT];
    assign phase2_low = r.running && r.full_bridge &&
        r.control_calibration[PHASE2_EN_BIT] && !r.p2;
    // trim logic acts on this; the period register is left as written
    assign calibrate_now_field = r.running ?
        r.control_calibration[CAL_FIELD_LSB +: 2] : CAL_NONE;
    assign dead_time_field = r.pulse_count_high_direction[5:4];
    assign motor_running = r.running;
    assign sda_out = 1'b0;
endmodule

// *** sim/ppic_host_model.sv ***
module ppic_host_model (
    output logic scl, // bus clock, high between frames
    output logic sda_drv, // low pulls data line
    input wire logic sda_line // resolved data line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // long low phase leaves the slave's late ack release clear of scl high
    task automatic xfer(input logic [7:0] b [6], input int n,
            output int acks);
        logic ok;
        acks = 0;
        ok = 1'b1;
        // stay off the core clock edge so no pin moves as it is sampled
        #5;
        sda_drv = 1'b0;
        #200 scl = 1'b0;
        for (int i = 0; i < n && ok; i++) begin
            for (int k = 7; k >= 0; k--) begin
                #100 sda_drv = b[i][k];
                #180 scl = 1'b1;
                #120 scl = 1'b0;
            end
            #100 sda_drv = 1'b1;
            #180 scl = 1'b1;
            #60 ok = !sda_line;
            #60 scl = 1'b0;
            if (ok) acks++;
        end
        #100 sda_drv = 1'b0;
        #180 scl = 1'b1;
        #200 sda_drv = 1'b1;
        #400;
    endtask
endmodule

// *** sim/ppic_top_monitor.sv ***
module ppic_top_monitor (
    input wire logic core_clk, // clock
    input wire logic rstn, // reset
    input wire logic powerdown_n_pin, // stand-by
    input wire logic scl_in, // bus clock
    input wire logic sda_out, // data value
    input wire logic sda_oe_n, // data pull
    input wire logic phase1_high, // drive
    input wire logic phase1_low, // drive
    input wire logic phase2_high, // drive
    input wire logic phase2_low, // drive
    input wire logic [1:0] calibrate_now_field, // cal
    input wire logic motor_running // running
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] since_ack;
    logic outs_low;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    assign outs_low = !(phase1_high | phase1_low | phase2_high | phase2_low);
    // saturates so a start long after any ack is still caught
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            since_ack <= 5'h1f;
        end else if (!sda_oe_n) begin
            since_ack <= 5'h00;
        end else if (since_ack != 5'h1f) begin
            since_ack <= since_ack + 5'h01;
        end
    end
    // ====================================================
    // assertions
    property p_sda_low; sda_out == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("data drive value not low");
    property p_ack_edge; !$stable(sda_oe_n) |-> !scl_in; endproperty
    a_ack_edge: assert property (p_ack_edge)
        else $error("ack changed while bus clock high");
    property p_ack_len;
        $fell(sda_oe_n) |-> !sda_oe_n [*6] ##[1:4] sda_oe_n;
    endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("ack not one bit slot long");
    property p_start; $rose(motor_running) |-> since_ack < 5'h10; endproperty
    a_start: assert property (p_start)
        else $error("motor started without a write");
    property p_edge_run;
        $rose(phase1_high) || $rose(phase2_high) |-> ##[0:1] motor_running;
    endproperty
    a_edge_run: assert property (p_edge_run)
        else $error("pulse issued while stopped");
    property p_idle; !motor_running && !$past(motor_running) |-> outs_low;
    endproperty
    a_idle: assert property (p_idle)
        else $error("drive outputs not low while stopped");
    property p_pd; !powerdown_n_pin [*6] |=> !motor_running; endproperty
    a_pd: assert property (p_pd)
        else $error("power-down did not stop motor");
    property p_cal_idle;
        !motor_running && !$past(motor_running)
            |-> calibrate_now_field == 2'h0;
    endproperty
    a_cal_idle: assert property (p_cal_idle)
        else $error("calibration requested while stopped");
endmodule

bind ppic_top ppic_top_monitor u_mon (
    .core_clk(core_clk), .rstn(rstn), .powerdown_n_pin(powerdown_n_pin),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .phase1_high(phase1_high), .phase1_low(phase1_low),
    .phase2_high(phase2_high), .phase2_low(phase2_low),
    .calibrate_now_field(calibrate_now_field),
    .motor_running(motor_running));

// *** sim/ppic_top_tb.sv ***
module ppic_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        int sel; int n; logic [7:0] b [6]; int acks; int run; int dt; int cal;
    } ppic_row_type;
    logic core_clk, rstn, powerdown_n_pin, addr_sel;
    logic scl, sda_drv, sda_line, sda_out, sda_oe_n;
    logic p1h, p1l, p2h, p2l, running, p1q, p2q, rec_clr;
    logic [1:0] cal, dt;
    int mismatches, checks_done, cyc, acks, n1, t1, t1p, f1, f2, hi1, nlo;
    ppic_row_type rows [9] = '{
        '{0, 6, '{8'ha8, 8'h00, 8'h6b, 8'h14, 8'h77, 8'hff},
            6, 1, 3, 2},
        '{0, 3, '{8'ha8, 8'h00, 8'h67, 8'h00, 8'h00, 8'h00}, 3, 1, 3, 1},
        '{0, 3, '{8'ha8, 8'h00, 8'h63, 8'h00, 8'h00, 8'h00}, 3, 1, 3, 0},
        '{0, 4, '{8'ha8, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 4, 0, 0, 0},
        '{1, 4, '{8'haa, 8'h02, 8'h37, 8'hff, 8'h00, 8'h00}, 4, 1, 3, 0},
        '{1, 4, '{8'ha8, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 1, 3, 0},
        '{0, 1, '{8'ha9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 0, 1, 3, 0},
        '{0, 3, '{8'ha8, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 1, 0, 0},
        '{0, 3, '{8'ha8, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 0, 0, 0}};
    assign sda_line = sda_drv & sda_oe_n; // pull-up, wired-and
    ppic_host_model u_host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    ppic_top u_dut (.core_clk(core_clk), .rstn(rstn),
        .powerdown_n_pin(powerdown_n_pin), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
        .phase1_high(p1h), .phase1_low(p1l), .phase2_high(p2h),
        .phase2_low(p2l), .calibrate_now_field(cal), .dead_time_field(dt),
        .motor_running(running));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ====================================================
    // pulse edge recorder, cycle stamps only
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        p1q <= p1h;
        p2q <= p2h;
        if (rec_clr) begin
            n1 <= 0;
            nlo <= 0;
            f1 <= -1;
            f2 <= -1;
        end else begin
            if (p1h && !p1q) begin
                n1 <= n1 + 1;
                t1p <= t1;
                t1 <= cyc;
                if (f1 < 0) f1 <= cyc;
            end
            if (!p1h && p1q) hi1 <= cyc - t1;
            if (p2h && !p2q && f2 < 0) f2 <= cyc;
            if (p1l) nlo <= nlo + 1;
        end
        if (cyc == 40000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            final_report();
        end
    end
    task automatic chk(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ====================================================
    // main sequence
    initial begin
        rec_clr = 1'b0;
        rstn = 1'b0;
        powerdown_n_pin = 1'b1;
        addr_sel = 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(running === 1'b0 && sda_oe_n === 1'b1, "reset state");
        foreach (rows[i]) begin
            addr_sel <= 1'(rows[i].sel);
            @(posedge core_clk);
            u_host.xfer(rows[i].b, rows[i].n, acks);
            repeat (4) @(posedge core_clk);
            chk(acks == rows[i].acks, "ack count");
            chk(running === 1'(rows[i].run), "running");
            chk(dt === 2'(rows[i].dt), "dead time");
            chk(cal === 2'(rows[i].cal), "calibration");
        end
        // a period of 20 steps keeps the quarter offset a whole count
        for (int d = 0; d < 3; d++) begin
            rec_clr <= 1'b1;
            @(posedge core_clk);
            rec_clr <= 1'b0;
            u_host.xfer('{8'ha8, 8'h00, d == 2 ? 8'h23 : 8'h03, 8'h14,
                d == 1 ? 8'h40 : 8'h00, 8'h03}, 6, acks);
            for (int w = 0; w < 300 && running !== 1'b0; w++)
                @(posedge core_clk);
            repeat (4) @(posedge core_clk);
            chk(n1 == 3, "pulse count");
            chk(t1 - t1p == 20, "pulse period");
            chk(hi1 == 10, "pulse width");
            chk((d == 1 ? f2 - f1 : f1 - f2) == 5, "phase lead");
            chk((nlo > 0) == (d != 2), "bridge mode");
        end
        // a 20-pulse count lasts 400 cycles, longer than one 4-byte write
        u_host.xfer('{8'ha8, 8'h02, 8'h00, 8'h14, 8'h00, 8'h00}, 4, acks);
        u_host.xfer('{8'ha8, 8'h02, 8'h00, 8'h14, 8'h00, 8'h00}, 4, acks);
        repeat (200) @(posedge core_clk);
        chk(running === 1'b1, "reload");
        u_host.xfer('{8'ha8, 8'h02, 8'h77, 8'hff, 8'h00, 8'h00}, 4, acks);
        chk(running === 1'b1 && dt === 2'h3, "long run");
        @(posedge core_clk);
        powerdown_n_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk({running, p1h, p1l, p2h, p2l} === 5'h00, "stand-by");
        powerdown_n_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(dt === 2'h0, "registers cleared");
        final_report();
    end
endmodule
